// ---- rtl/ppc_params.svh ----
// Register map, field positions, reset images and timing counts of the pump / level config bank.
// Assumes it is included by the package and design files by its bare name.
`ifndef PPC_PARAMS_SVH
`define PPC_PARAMS_SVH

// ==========================================================
// register offsets (command page 1)
`define PPC_ADDR_PUMP_CTRL 8'h40
`define PPC_ADDR_NEG_CYC 8'h41
`define PPC_ADDR_GATE_CYC 8'h42
`define PPC_ADDR_EXT_CYC 8'h43
`define PPC_ADDR_POS_GAMMA 8'h50
`define PPC_ADDR_NEG_GAMMA 8'h51
`define PPC_ADDR_FWD_MSB 8'h52
`define PPC_ADDR_FWD_LSB 8'h53
`define PPC_ADDR_BWD_MSB 8'h54
`define PPC_ADDR_BWD_LSB 8'h55
`define PPC_ADDR_LVL_SRC 8'h56
`define PPC_ADDR_LVD 8'h58

// ==========================================================
// reset images (power-on, software and hardware reset alike)
`define PPC_RST_PUMP_CTRL 8'h33
`define PPC_RST_NEG_CYC 8'h33
`define PPC_RST_GATE_CYC 8'h44
`define PPC_RST_EXT_CYC 8'h55
`define PPC_RST_GAMMA 8'h95
`define PPC_RST_LVL_MSB 8'h00
`define PPC_RST_LVL_LSB 8'h7B
`define PPC_RST_LVL_SRC 8'h00
`define PPC_RST_LVD 8'h00

// ==========================================================
// field positions
`define PPC_EXT_MODE_MSB 6
`define PPC_EXT_MODE_LSB 5
`define PPC_FIXED_ONE_BIT 4
`define PPC_NEG_EN_BIT 1
`define PPC_GATE_EN_BIT 0
`define PPC_CYC_A_MSB 6
`define PPC_CYC_A_LSB 4
`define PPC_CYC_B_MSB 2
`define PPC_CYC_B_LSB 0
`define PPC_LVL_TOP_BIT 0
`define PPC_FWD_SRC_BIT 0
`define PPC_BWD_SRC_BIT 4
`define PPC_LVD_BIT 7
`define PPC_READ_ZERO 8'h00

// ==========================================================
// valid code ranges
`define PPC_GAMMA_MIN 8'h10
`define PPC_GAMMA_MAX 8'hEA
`define PPC_LEVEL_MIN 9'h010
`define PPC_LEVEL_MAX 9'h14D

// ==========================================================
// pumping cycle codes and half-periods counted in quarter-line ticks
`define PPC_CYC_16H 3'h0
`define PPC_CYC_8H 3'h1
`define PPC_CYC_4H 3'h2
`define PPC_CYC_2H 3'h3
`define PPC_CYC_1H 3'h4
`define PPC_CYC_HALF_H 3'h5
`define PPC_HP_16H 6'h20
`define PPC_HP_8H 6'h10
`define PPC_HP_4H 6'h08
`define PPC_HP_2H 6'h04
`define PPC_HP_1H 6'h02
`define PPC_HP_HALF_H 6'h01
`define PPC_HP_NONE 6'h00

`endif

// ---- rtl/ppc_pkg.sv ----
// Types and shared decode functions of the pump / level config bank.
// Assumes ppc_params.svh is on the include path.
`include "ppc_params.svh"

package ppc_pkg;

	typedef enum logic [1:0] {
		EXT_X1P5 = 2'b00,
		EXT_X2 = 2'b01,
		EXT_X3 = 2'b10,
		EXT_OFF = 2'b11
	} ppc_ext_mode_t;

	typedef struct packed {
		logic wr;
		logic rd;
		logic [7:0] addr;
		logic [7:0] data;
	} ppc_cmd_t;

	typedef struct packed {
		logic valid;
		logic [7:0] data;
	} ppc_rsp_t;

	// half-period of a pump clock in quarter-line ticks; zero for reserved codes
	function automatic logic [5:0] ppc_half_period(input logic [2:0] code);
		logic [5:0] hp;
		hp = `PPC_HP_NONE;
		case (code)
			`PPC_CYC_16H: hp = `PPC_HP_16H;
			`PPC_CYC_8H: hp = `PPC_HP_8H;
			`PPC_CYC_4H: hp = `PPC_HP_4H;
			`PPC_CYC_2H: hp = `PPC_HP_2H;
			`PPC_CYC_1H: hp = `PPC_HP_1H;
			`PPC_CYC_HALF_H: hp = `PPC_HP_HALF_H;
			default: hp = `PPC_HP_NONE;
		endcase
		return hp;
	endfunction

	function automatic logic ppc_gamma_ok(input logic [7:0] code);
		return (code >= `PPC_GAMMA_MIN) && (code <= `PPC_GAMMA_MAX);
	endfunction

	function automatic logic ppc_level_ok(input logic [8:0] code);
		return (code >= `PPC_LEVEL_MIN) && (code <= `PPC_LEVEL_MAX);
	endfunction

endpackage

// ---- rtl/ppc_cycle_gen.sv ----
// One pump clock: toggles every half-period of the selected pumping cycle.
// Assumes tick_i pulses four times per line period, synchronous to sys_clk_i.
`timescale 1ns/1ps
`include "ppc_params.svh"

module ppc_cycle_gen
	import ppc_pkg::*;
(
	input wire logic sys_clk_i,
	input wire logic reset_i,
	input wire logic tick_i,
	input wire logic enable_i,
	input wire logic [2:0] cycle_i,
	output logic pump_clk_o
);

	typedef struct packed {
		logic [5:0] cnt;
		logic clk;
	} ppc_gen_state_t;

	ppc_gen_state_t st_q;
	ppc_gen_state_t st_d;
	logic [5:0] hp;

	assign hp = ppc_half_period(cycle_i);

	// ==========================================================
	// counter
	always_comb begin
		st_d = st_q;
		if (reset_i || !enable_i || hp == `PPC_HP_NONE) begin
			// reserved codes stop the clock rather than guess a rate
			st_d = '0;
		end else if (tick_i) begin
			if (st_q.cnt >= hp - 6'h01) begin // [R5]
				st_d.cnt = '0;
				st_d.clk = ~st_q.clk;
			end else begin
				st_d.cnt = st_q.cnt + 6'h01;
			end
		end
	end

	always_ff @(posedge sys_clk_i) begin
		st_q <= st_d;
	end

	assign pump_clk_o = st_q.clk;

	// ==========================================================
	// checks
	property p_toggle_on_tick;
		@(posedge sys_clk_i) disable iff (reset_i)
		$changed(pump_clk_o) |-> $past(tick_i) || !$past(enable_i) || $past(hp) == `PPC_HP_NONE;
	endproperty
	a_toggle_on_tick: assert property (p_toggle_on_tick) else $error("pump clock moved without a tick"); // [R5]

endmodule

// ---- rtl/ppc_ext_clk.sv ----
// Non-overlapping clock pair to the external pump controller, shaped by the mode field.
// Assumes base_clk_i is the registered external pump clock from ppc_cycle_gen.
`timescale 1ns/1ps

module ppc_ext_clk
	import ppc_pkg::*;
(
	input wire logic sys_clk_i,
	input wire logic reset_i,
	input wire logic base_clk_i,
	input wire ppc_ext_mode_t mode_i,
	output logic pump_clock_out_pos_o,
	output logic pump_clock_out_neg_o
);

	typedef struct packed {
		logic prev;
		logic [1:0] ph;
		logic pos;
		logic neg;
	} ppc_ext_state_t;

	ppc_ext_state_t st_q;
	ppc_ext_state_t st_d;

	// ==========================================================
	// phase and waveform
	always_comb begin
		st_d = st_q;
		st_d.prev = base_clk_i;
		if (base_clk_i != st_q.prev) begin
			st_d.ph = st_q.ph + 2'h1;
		end
		case (mode_i) // [R1]
			EXT_X1P5: begin
				st_d.pos = (st_d.ph == 2'h0);
				st_d.neg = (st_d.ph == 2'h2);
			end
			EXT_X2: begin
				st_d.pos = ~st_d.ph[0];
				st_d.neg = st_d.ph[0];
			end
			EXT_X3: begin
				st_d.pos = ~st_d.ph[1];
				st_d.neg = st_d.ph[1];
			end
			default: begin
				st_d.ph = '0;
				st_d.pos = 1'b0;
				st_d.neg = 1'b0;
			end
		endcase
		if (reset_i) begin
			st_d = '0;
		end
	end

	always_ff @(posedge sys_clk_i) begin
		st_q <= st_d;
	end

	assign pump_clock_out_pos_o = st_q.pos;
	assign pump_clock_out_neg_o = st_q.neg;

	// ==========================================================
	// checks
	property p_never_both_high;
		@(posedge sys_clk_i) disable iff (reset_i)
		!(pump_clock_out_pos_o && pump_clock_out_neg_o);
	endproperty
	a_never_both_high: assert property (p_never_both_high) else $error("external pump outputs overlap"); // [R1]

endmodule

// ---- rtl/ppc_regs.sv ----
// Pump clock, gamma reference and common level configuration bank with its pump clock outputs.
// Assumes host commands arrive as single-cycle strobes synchronous to sys_clk_i.
`timescale 1ns/1ps
`include "ppc_params.svh"

// Notes on behaviour
// (R1) mode 0..3 gives 1.5x, 2x, 3x waveforms, or both external outputs low.
// (R2) host sets the external mode before sleep-out when external pumping is used.
// (R3) negative-rail enable bit runs or stops that pump clock.
// (R4) gate-rail enable bit zero runs or stops that pump clock.
// (R5) cycle codes 0..5 mean 16, 8, 4, 2, 1, half line; others reserved.
// (R6) negative rail uses field A in normal mode, field B in idle.
// (R7) gate rails use field A in normal mode, field B in idle.
// (R8) external pump clock uses field A in normal mode, field B in idle.
// (R9) host picks the smallest step-up setting that still meets voltage.
// (R10) positive gamma code valid 10h to EAh, 12 mV per step.
// (R11) negative gamma code has the same range, opposite sign.
// (R12) forward level is nine bits from 52h bit 0 and 53h, scan flag zero.
// (R13) backward level is nine bits from 54h bit 0 and 55h, scan flag one.
// (R14) nine-bit level codes valid 010h to 14Dh, 12 mV per step.
// (R15) forward source bit picks register pair or stored memory value.
// (R16) backward source bit four picks register pair or stored memory value.
// (R17) memory programming sets the source bits without a host write.
// (R18) low-voltage detect runs when bit seven is 0, off when 1.
// (R19) all registers accept writes and reads in every power state.
// (R20) fixed bits read as their constants and ignore writes.
module ppc_regs
	import ppc_pkg::*;
(
	input wire logic sys_clk_i,
	input wire logic reset_i,
	input wire ppc_cmd_t cmd_i,
	output ppc_rsp_t rsp_o,
	input wire logic tick_i,
	input wire logic idle_mode_i,
	input wire logic vertical_scan_direction_i,
	input wire logic nvm_program_i,
	input wire logic [8:0] nvm_forward_level_i,
	input wire logic [8:0] nvm_backward_level_i,
	output logic negative_rail_pump_clk_o,
	output logic gate_rail_pump_clk_o,
	output logic pump_clock_out_pos_o,
	output logic pump_clock_out_neg_o,
	output logic [7:0] positive_gamma_reference_code_o,
	output logic [7:0] negative_gamma_reference_code_o,
	output logic gamma_codes_valid_o,
	output logic [8:0] common_level_o,
	output logic common_level_valid_o,
	output logic low_voltage_detect_en_o
);

	typedef struct packed {
		ppc_ext_mode_t ext_mode;
		logic neg_en;
		logic gate_en;
		logic [2:0] neg_a;
		logic [2:0] neg_b;
		logic [2:0] gate_a;
		logic [2:0] gate_b;
		logic [2:0] ext_a;
		logic [2:0] ext_b;
		logic [7:0] pos_gamma;
		logic [7:0] neg_gamma;
		logic [8:0] fwd_lvl;
		logic [8:0] bwd_lvl;
		logic fwd_src;
		logic bwd_src;
		logic lvd_off;
		ppc_rsp_t rsp;
		logic [8:0] level;
		logic level_ok;
		logic gamma_ok;
	} ppc_state_t;

	ppc_state_t st_q;
	ppc_state_t st_d;
	logic [2:0] neg_sel;
	logic [2:0] gate_sel;
	logic [2:0] ext_sel;
	logic ext_clk;

	// ==========================================================
	// register write: only stored fields are taken, fixed bits are dropped
	function automatic ppc_state_t reg_write(input ppc_state_t s, input logic [7:0] a, input logic [7:0] d);
		ppc_state_t r;
		r = s;
		if (a == `PPC_ADDR_PUMP_CTRL) begin
			r.ext_mode = ppc_ext_mode_t'(d[`PPC_EXT_MODE_MSB:`PPC_EXT_MODE_LSB]);
			r.neg_en = d[`PPC_NEG_EN_BIT];
			r.gate_en = d[`PPC_GATE_EN_BIT];
		end else if (a == `PPC_ADDR_NEG_CYC) begin
			r.neg_a = d[`PPC_CYC_A_MSB:`PPC_CYC_A_LSB];
			r.neg_b = d[`PPC_CYC_B_MSB:`PPC_CYC_B_LSB];
		end else if (a == `PPC_ADDR_GATE_CYC) begin
			r.gate_a = d[`PPC_CYC_A_MSB:`PPC_CYC_A_LSB];
			r.gate_b = d[`PPC_CYC_B_MSB:`PPC_CYC_B_LSB];
		end else if (a == `PPC_ADDR_EXT_CYC) begin
			r.ext_a = d[`PPC_CYC_A_MSB:`PPC_CYC_A_LSB];
			r.ext_b = d[`PPC_CYC_B_MSB:`PPC_CYC_B_LSB];
		end else if (a == `PPC_ADDR_POS_GAMMA) begin
			r.pos_gamma = d;
		end else if (a == `PPC_ADDR_NEG_GAMMA) begin
			r.neg_gamma = d;
		end else if (a == `PPC_ADDR_FWD_MSB) begin
			r.fwd_lvl[8] = d[`PPC_LVL_TOP_BIT]; // [R12]
		end else if (a == `PPC_ADDR_FWD_LSB) begin
			r.fwd_lvl[7:0] = d;
		end else if (a == `PPC_ADDR_BWD_MSB) begin
			r.bwd_lvl[8] = d[`PPC_LVL_TOP_BIT]; // [R13]
		end else if (a == `PPC_ADDR_BWD_LSB) begin
			r.bwd_lvl[7:0] = d;
		end else if (a == `PPC_ADDR_LVL_SRC) begin
			r.fwd_src = d[`PPC_FWD_SRC_BIT];
			r.bwd_src = d[`PPC_BWD_SRC_BIT];
		end else if (a == `PPC_ADDR_LVD) begin
			r.lvd_off = d[`PPC_LVD_BIT];
		end
		return r;
	endfunction

	// register read: fixed ones and zeros come back as constants
	function automatic logic [7:0] reg_read(input ppc_state_t s, input logic [7:0] a);
		logic [7:0] d;
		d = `PPC_READ_ZERO;
		if (a == `PPC_ADDR_PUMP_CTRL) begin
			d[`PPC_EXT_MODE_MSB:`PPC_EXT_MODE_LSB] = s.ext_mode;
			d[`PPC_FIXED_ONE_BIT] = 1'b1; // [R20]
			d[`PPC_NEG_EN_BIT] = s.neg_en;
			d[`PPC_GATE_EN_BIT] = s.gate_en;
		end else if (a == `PPC_ADDR_NEG_CYC) begin
			d[`PPC_CYC_A_MSB:`PPC_CYC_A_LSB] = s.neg_a;
			d[`PPC_CYC_B_MSB:`PPC_CYC_B_LSB] = s.neg_b;
		end else if (a == `PPC_ADDR_GATE_CYC) begin
			d[`PPC_CYC_A_MSB:`PPC_CYC_A_LSB] = s.gate_a;
			d[`PPC_CYC_B_MSB:`PPC_CYC_B_LSB] = s.gate_b;
		end else if (a == `PPC_ADDR_EXT_CYC) begin
			d[`PPC_CYC_A_MSB:`PPC_CYC_A_LSB] = s.ext_a;
			d[`PPC_CYC_B_MSB:`PPC_CYC_B_LSB] = s.ext_b;
		end else if (a == `PPC_ADDR_POS_GAMMA) begin
			d = s.pos_gamma;
		end else if (a == `PPC_ADDR_NEG_GAMMA) begin
			d = s.neg_gamma;
		end else if (a == `PPC_ADDR_FWD_MSB) begin
			d[`PPC_LVL_TOP_BIT] = s.fwd_lvl[8];
		end else if (a == `PPC_ADDR_FWD_LSB) begin
			d = s.fwd_lvl[7:0];
		end else if (a == `PPC_ADDR_BWD_MSB) begin
			d[`PPC_LVL_TOP_BIT] = s.bwd_lvl[8];
		end else if (a == `PPC_ADDR_BWD_LSB) begin
			d = s.bwd_lvl[7:0];
		end else if (a == `PPC_ADDR_LVL_SRC) begin
			d[`PPC_FWD_SRC_BIT] = s.fwd_src;
			d[`PPC_BWD_SRC_BIT] = s.bwd_src;
		end else if (a == `PPC_ADDR_LVD) begin
			d[`PPC_LVD_BIT] = s.lvd_off;
		end
		return d;
	endfunction

	function automatic ppc_state_t reset_image();
		ppc_state_t r;
		r = '0;
		r = reg_write(r, `PPC_ADDR_PUMP_CTRL, `PPC_RST_PUMP_CTRL);
		r = reg_write(r, `PPC_ADDR_NEG_CYC, `PPC_RST_NEG_CYC);
		r = reg_write(r, `PPC_ADDR_GATE_CYC, `PPC_RST_GATE_CYC);
		r = reg_write(r, `PPC_ADDR_EXT_CYC, `PPC_RST_EXT_CYC);
		r = reg_write(r, `PPC_ADDR_POS_GAMMA, `PPC_RST_GAMMA);
		r = reg_write(r, `PPC_ADDR_NEG_GAMMA, `PPC_RST_GAMMA);
		r = reg_write(r, `PPC_ADDR_FWD_MSB, `PPC_RST_LVL_MSB);
		r = reg_write(r, `PPC_ADDR_FWD_LSB, `PPC_RST_LVL_LSB);
		r = reg_write(r, `PPC_ADDR_BWD_MSB, `PPC_RST_LVL_MSB);
		r = reg_write(r, `PPC_ADDR_BWD_LSB, `PPC_RST_LVL_LSB);
		r = reg_write(r, `PPC_ADDR_LVL_SRC, `PPC_RST_LVL_SRC);
		r = reg_write(r, `PPC_ADDR_LVD, `PPC_RST_LVD);
		return r;
	endfunction

	// ==========================================================
	// state update
	always_comb begin
		st_d = st_q;
		st_d.rsp = '0;
		// no power-state gating: sleep and idle leave the bank fully open
		if (cmd_i.wr) begin
			st_d = reg_write(st_d, cmd_i.addr, cmd_i.data); // [R19]
		end
		if (cmd_i.rd) begin
			st_d.rsp.valid = 1'b1;
			st_d.rsp.data = reg_read(st_q, cmd_i.addr);
		end
		// programming beats a same-cycle host write of the source bits
		if (nvm_program_i) begin
			st_d.fwd_src = 1'b1; // [R17]
			st_d.bwd_src = 1'b1; // [R17]
		end
		if (!vertical_scan_direction_i) begin
			st_d.level = st_q.fwd_src ? nvm_forward_level_i : st_q.fwd_lvl; // [R12] [R15]
		end else begin
			st_d.level = st_q.bwd_src ? nvm_backward_level_i : st_q.bwd_lvl; // [R13] [R16]
		end
		st_d.level_ok = ppc_level_ok(st_d.level); // [R14]
		st_d.gamma_ok = ppc_gamma_ok(st_d.pos_gamma) && ppc_gamma_ok(st_d.neg_gamma); // [R10] [R11]
		if (reset_i) begin
			st_d = reset_image();
		end
	end

	always_ff @(posedge sys_clk_i) begin
		st_q <= st_d;
	end

	// ==========================================================
	// pump clocks
	assign neg_sel = idle_mode_i ? st_q.neg_b : st_q.neg_a; // [R6]
	assign gate_sel = idle_mode_i ? st_q.gate_b : st_q.gate_a; // [R7]
	assign ext_sel = idle_mode_i ? st_q.ext_b : st_q.ext_a; // [R8]

	ppc_cycle_gen u_neg_gen (
		.sys_clk_i(sys_clk_i),
		.reset_i(reset_i),
		.tick_i(tick_i),
		.enable_i(st_q.neg_en), // [R3]
		.cycle_i(neg_sel),
		.pump_clk_o(negative_rail_pump_clk_o)
	);

	ppc_cycle_gen u_gate_gen (
		.sys_clk_i(sys_clk_i),
		.reset_i(reset_i),
		.tick_i(tick_i),
		.enable_i(st_q.gate_en), // [R4]
		.cycle_i(gate_sel),
		.pump_clk_o(gate_rail_pump_clk_o)
	);

	ppc_cycle_gen u_ext_gen (
		.sys_clk_i(sys_clk_i),
		.reset_i(reset_i),
		.tick_i(tick_i),
		.enable_i(st_q.ext_mode != EXT_OFF), // [R1]
		.cycle_i(ext_sel),
		.pump_clk_o(ext_clk)
	);

	ppc_ext_clk u_ext_clk (
		.sys_clk_i(sys_clk_i),
		.reset_i(reset_i),
		.base_clk_i(ext_clk),
		.mode_i(st_q.ext_mode),
		.pump_clock_out_pos_o(pump_clock_out_pos_o),
		.pump_clock_out_neg_o(pump_clock_out_neg_o)
	);

	assign rsp_o = st_q.rsp;
	assign positive_gamma_reference_code_o = st_q.pos_gamma;
	assign negative_gamma_reference_code_o = st_q.neg_gamma;
	assign gamma_codes_valid_o = st_q.gamma_ok;
	assign common_level_o = st_q.level;
	assign common_level_valid_o = st_q.level_ok;
	assign low_voltage_detect_en_o = ~st_q.lvd_off; // [R18]

	// ==========================================================
	// checks
	default clocking cb @(posedge sys_clk_i); endclocking
	default disable iff (reset_i);

	sequence s_off_held;
		(st_q.ext_mode == EXT_OFF)[*3];
	endsequence
	property p_ext_off_low;
		s_off_held |-> !pump_clock_out_pos_o && !pump_clock_out_neg_o;
	endproperty
	a_ext_off_low: assert property (p_ext_off_low) else $error("external outputs not low in power down"); // [R1]

	property p_neg_stop;
		(!st_q.neg_en)[*2] |-> !negative_rail_pump_clk_o;
	endproperty
	a_neg_stop: assert property (p_neg_stop) else $error("negative rail clock runs while disabled"); // [R3]

	property p_gate_stop;
		(!st_q.gate_en)[*2] |-> !gate_rail_pump_clk_o;
	endproperty
	a_gate_stop: assert property (p_gate_stop) else $error("gate rail clock runs while disabled"); // [R4]

	property p_neg_idle_field;
		(idle_mode_i && st_q.neg_b > `PPC_CYC_HALF_H)[*2] |-> !negative_rail_pump_clk_o;
	endproperty
	a_neg_idle_field: assert property (p_neg_idle_field) else $error("idle field not used for negative rail"); // [R6]

	property p_gate_normal_field;
		(!idle_mode_i && st_q.gate_a > `PPC_CYC_HALF_H)[*2] |-> !gate_rail_pump_clk_o;
	endproperty
	a_gate_normal_field: assert property (p_gate_normal_field) else $error("normal field not used for gate rail"); // [R7]

	property p_gamma_write;
		cmd_i.wr && cmd_i.addr == `PPC_ADDR_POS_GAMMA && !reset_i |=>
			positive_gamma_reference_code_o == $past(cmd_i.data) ##1
			gamma_codes_valid_o == (ppc_gamma_ok(positive_gamma_reference_code_o) &&
				ppc_gamma_ok(negative_gamma_reference_code_o));
	endproperty
	a_gamma_write: assert property (p_gamma_write) else $error("gamma code or validity wrong"); // [R10]

	property p_fwd_level;
		!vertical_scan_direction_i && !st_q.fwd_src |=> common_level_o == $past(st_q.fwd_lvl);
	endproperty
	a_fwd_level: assert property (p_fwd_level) else $error("forward level not selected"); // [R12]

	property p_nvm_sets_src;
		nvm_program_i |=> st_q.fwd_src && st_q.bwd_src;
	endproperty
	a_nvm_sets_src: assert property (p_nvm_sets_src) else $error("source bits not set by programming"); // [R17]

	property p_lvd;
		cmd_i.wr && cmd_i.addr == `PPC_ADDR_LVD |=> low_voltage_detect_en_o == !$past(cmd_i.data[`PPC_LVD_BIT]);
	endproperty
	a_lvd: assert property (p_lvd) else $error("low voltage detect polarity wrong"); // [R18]

	property p_fixed_bits;
		cmd_i.rd && cmd_i.addr == `PPC_ADDR_PUMP_CTRL |=>
			rsp_o.valid && rsp_o.data[`PPC_FIXED_ONE_BIT] && !rsp_o.data[7] && rsp_o.data[3:2] == 2'h0;
	endproperty
	a_fixed_bits: assert property (p_fixed_bits) else $error("fixed bits read wrong"); // [R20]

endmodule

// ---- verification/ppc_host_model.sv ----
// Host model: issues single-cycle register commands to the bank.
// Assumes callers sample nothing in the edge time step.
`timescale 1ns/1ps

module ppc_host_model
	import ppc_pkg::*;
(
	input wire logic sys_clk_i,
	input wire ppc_rsp_t rsp_i,
	output ppc_cmd_t cmd_o
);
	// external mode is written before any power-up step
	// cycle codes stay at the smallest setting the test needs
	initial begin
		cmd_o = '0;
	end
	// released lines show the inverse, not a stale copy
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge sys_clk_i);
		cmd_o <= '{wr: 1'b1, rd: 1'b0, addr: a, data: d};
		@(posedge sys_clk_i);
		cmd_o <= '{wr: 1'b0, rd: 1'b0, addr: ~a, data: ~d};
	endtask
	task automatic rd(input logic [7:0] a, output logic [7:0] d, output logic v);
		@(posedge sys_clk_i);
		cmd_o <= '{wr: 1'b0, rd: 1'b1, addr: a, data: 8'h00};
		@(posedge sys_clk_i);
		cmd_o <= '{wr: 1'b0, rd: 1'b0, addr: ~a, data: 8'hFF};
		@(negedge sys_clk_i);
		v = rsp_i.valid;
		d = rsp_i.data;
	endtask
endmodule

// ---- verification/tb.sv ----
// Bench for the pump / level config bank, driven through the host model.
// Assumes ppc_pkg and ppc_host_model are compiled first.
`timescale 1ns/1ps

module tb
	import ppc_pkg::*;
;
	logic sys_clk_i = 1'b0;
	logic reset_i = 1'b1;
	ppc_cmd_t cmd;
	ppc_rsp_t rsp;
	logic tick_i = 1'b0, tick_run = 1'b0, idle_mode_i = 1'b0, scan = 1'b0, nvm_prog = 1'b0;
	logic [8:0] nvm_fwd = 9'h0AB, nvm_bwd = 9'h0CD, level;
	logic neg_clk, gate_clk, ext_pos, ext_neg, gam_ok, lvl_ok, low_voltage_detect_control;
	logic [7:0] pos_gam, neg_gam;
	logic [3:0] pv = 4'h0;
	int miscompares = 0, n_tests = 0, cyc = 0, tn = 0, tg = 0, tp = 0, tq = 0, both = 0;
	logic [7:0] ad [13] = '{8'h40, 8'h41, 8'h42, 8'h43, 8'h50, 8'h51, 8'h52, 8'h53, 8'h54, 8'h55, 8'h56, 8'h58, 8'h57};
	logic [7:0] rv [13] = '{8'h33, 8'h33, 8'h44, 8'h55, 8'h95, 8'h95, 8'h00, 8'h7B, 8'h00, 8'h7B, 8'h00, 8'h00, 8'h00};
	logic [7:0] mf [13] = '{8'h73, 8'h77, 8'h77, 8'h77, 8'hFF, 8'hFF, 8'h01, 8'hFF, 8'h01, 8'hFF, 8'h11, 8'h80, 8'h00};
	logic [7:0] gv [4] = '{8'h0F, 8'h10, 8'hEA, 8'hEB};
	logic [8:0] lv [4] = '{9'h00F, 9'h010, 9'h14D, 9'h14E};

	always #2.5 sys_clk_i = ~sys_clk_i;
	// quarter-line tick every second cycle
	always @(posedge sys_clk_i) tick_i <= tick_run & ~tick_i;
	// ==========================================================
	// activity counters, sampled away from the launching edge
	always @(negedge sys_clk_i) begin
		if (neg_clk !== pv[0]) tn++;
		if (gate_clk !== pv[1]) tg++;
		if (ext_pos !== pv[2]) tp++;
		if (ext_neg !== pv[3]) tq++;
		if (ext_pos === 1'b1 && ext_neg === 1'b1) both++;
		pv = {ext_neg, ext_pos, gate_clk, neg_clk};
	end
	always @(posedge sys_clk_i) begin
		cyc++;
		if (cyc == 20000) begin
			miscompares++;
			finish_test();
		end
	end

	ppc_regs uut (
		.sys_clk_i(sys_clk_i),
		.reset_i(reset_i),
		.cmd_i(cmd),
		.rsp_o(rsp),
		.tick_i(tick_i),
		.idle_mode_i(idle_mode_i),
		.vertical_scan_direction_i(scan),
		.nvm_program_i(nvm_prog),
		.nvm_forward_level_i(nvm_fwd),
		.nvm_backward_level_i(nvm_bwd),
		.negative_rail_pump_clk_o(neg_clk),
		.gate_rail_pump_clk_o(gate_clk),
		.pump_clock_out_pos_o(ext_pos),
		.pump_clock_out_neg_o(ext_neg),
		.positive_gamma_reference_code_o(pos_gam),
		.negative_gamma_reference_code_o(neg_gam),
		.gamma_codes_valid_o(gam_ok),
		.common_level_o(level),
		.common_level_valid_o(lvl_ok),
		.low_voltage_detect_en_o(low_voltage_detect_control)
	);
	ppc_host_model host (
		.sys_clk_i(sys_clk_i),
		.rsp_i(rsp),
		.cmd_o(cmd)
	);

	// ==========================================================
	// helpers
	task automatic chk(input logic [8:0] got, input logic [8:0] exp, input string m);
		n_tests++;
		if (got !== exp) begin
			miscompares++;
			$display("mismatch at %0t: %s got %h exp %h", $time, m, got, exp);
		end
	endtask
	task automatic near(input int x, input int e, input string m);
		chk({8'h00, x >= e - 1 && x <= e + 1}, 9'h001, m);
	endtask
	task automatic rdchk(input logic [7:0] a, input logic [7:0] e);
		logic [7:0] d;
		logic v;
		host.rd(a, d, v);
		chk({8'h00, v}, 9'h001, "read valid");
		chk({1'b0, d}, {1'b0, e}, "read data");
	endtask
	task automatic settle();
		repeat (3) @(posedge sys_clk_i);
		@(negedge sys_clk_i);
	endtask
	task automatic measure();
		repeat (4) @(posedge sys_clk_i);
		tn = 0;
		tg = 0;
		tp = 0;
		tq = 0;
		both = 0;
		repeat (256) @(posedge sys_clk_i);
	endtask
	task automatic do_reset();
		@(posedge sys_clk_i);
		reset_i <= 1'b1;
		repeat (6) @(posedge sys_clk_i);
		reset_i <= 1'b0;
	endtask
	task automatic finish_test();
		$display("comparisons %0d miscompares %0d", n_tests, miscompares);
		if (miscompares == 0 && n_tests > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask

	// ==========================================================
	// scenarios
	task automatic t_regs();
		for (int i = 0; i < 13; i++) rdchk(ad[i], rv[i]);
		chk(level, 9'h07B, "level reset");
		chk({8'h00, low_voltage_detect_control}, 9'h001, "lvd reset");
		for (int i = 0; i < 13; i++) begin
			host.wr(ad[i], 8'hFF);
			rdchk(ad[i], mf[i]);
		end
		// reads end on a falling edge; inputs move only on the rising one
		@(posedge sys_clk_i);
		idle_mode_i <= 1'b1;
		for (int i = 0; i < 13; i++) begin
			host.wr(ad[i], 8'h00);
			rdchk(ad[i], (i == 0) ? 8'h10 : 8'h00);
		end
		@(posedge sys_clk_i);
		idle_mode_i <= 1'b0;
		do_reset();
		for (int i = 0; i < 13; i++) rdchk(ad[i], rv[i]);
		chk(level, 9'h07B, "level after reset");
		$display("test regs done");
	endtask
	task automatic t_gamma();
		for (int i = 0; i < 4; i++) begin
			host.wr(8'h50, gv[i]);
			host.wr(8'h51, gv[i]);
			settle();
			chk({1'b0, pos_gam}, {1'b0, gv[i]}, "pos gamma");
			chk({1'b0, neg_gam}, {1'b0, gv[i]}, "neg gamma");
			chk({8'h00, gam_ok}, {8'h00, gv[i] >= 8'h10 && gv[i] <= 8'hEA}, "gamma range");
		end
		$display("test gamma done");
	endtask
	task automatic t_level();
		for (int i = 0; i < 4; i++) begin
			host.wr(8'h52, {7'h00, lv[i][8]});
			host.wr(8'h53, lv[i][7:0]);
			settle();
			chk(level, lv[i], "fwd level");
			chk({8'h00, lvl_ok}, {8'h00, lv[i] >= 9'h010 && lv[i] <= 9'h14D}, "level range");
		end
		host.wr(8'h54, 8'h01);
		host.wr(8'h55, 8'h23);
		scan <= 1'b1;
		settle();
		chk(level, 9'h123, "bwd level");
		fork
			host.wr(8'h56, 8'h00);
			begin
				@(posedge sys_clk_i);
				nvm_prog <= 1'b1;
				@(posedge sys_clk_i);
				nvm_prog <= 1'b0;
			end
		join
		rdchk(8'h56, 8'h11);
		chk(level, nvm_bwd, "bwd stored");
		host.wr(8'h56, 8'h01);
		settle();
		chk(level, 9'h123, "bwd pair");
		host.wr(8'h56, 8'h10);
		scan <= 1'b0;
		settle();
		chk(level, 9'h14E, "fwd pair");
		host.wr(8'h56, 8'h01);
		settle();
		chk(level, nvm_fwd, "fwd stored");
		host.wr(8'h58, 8'h80);
		settle();
		chk({8'h00, low_voltage_detect_control}, 9'h000, "lvd off");
		$display("test level done");
	endtask
	task automatic t_pump();
		do_reset();
		tick_run <= 1'b1;
		for (int c = 0; c < 6; c++) begin
			host.wr(8'h41, {1'b0, c[2:0], 4'h7});
			measure();
			near(tn, 4 << c, "neg rate");
		end
		host.wr(8'h41, 8'h65);
		host.wr(8'h42, 8'h75);
		measure();
		near(tn, 0, "reserved code");
		near(tg, 0, "gate normal");
		idle_mode_i <= 1'b1;
		measure();
		near(tn, 128, "neg idle");
		near(tg, 128, "gate idle");
		host.wr(8'h43, 8'h75);
		for (int m = 0; m < 4; m++) begin
			host.wr(8'h40, {1'b0, m[1:0], 5'h13});
			measure();
			chk({8'h00, tp != 0}, {8'h00, m != 3}, "ext activity");
			chk({8'h00, tq != 0}, {8'h00, m != 3}, "ext neg activity");
			chk({8'h00, both == 0}, 9'h001, "ext overlap");
		end
		@(negedge sys_clk_i);
		chk({7'h00, ext_pos, ext_neg}, 9'h000, "ext power down");
		host.wr(8'h40, 8'h30);
		measure();
		near(tn, 0, "neg stopped");
		near(tg, 0, "gate stopped");
		host.wr(8'h40, 8'h33);
		idle_mode_i <= 1'b0;
		measure();
		near(tp, 0, "ext normal field");
		$display("test pump done");
	endtask

	initial begin
		repeat (6) @(posedge sys_clk_i);
		reset_i <= 1'b0;
		t_regs();
		t_gamma();
		t_level();
		t_pump();
		finish_test();
	end
endmodule
